// >>> verilog/pwg_pkg.sv
`default_nettype none
package pwg_pkg;
    localparam int NGEN = 4;
    localparam int NFLT = 4;
    localparam int DW = 32;
    localparam int AW = 9;
    localparam int BLK_LSB = 6;
    localparam int OFS_LSB = 2;
    localparam logic [2:0] BLK_MOD = 3'h0;
    localparam logic [2:0] BLK_GEN0 = 3'h1;
    localparam logic [2:0] BLK_LAST = 3'h4;
    localparam logic [3:0] OFS_MOD_IEN = 4'h0;
    localparam logic [3:0] OFS_MOD_RIS = 4'h1;
    localparam logic [3:0] OFS_MOD_MIS = 4'h2;
    localparam logic [3:0] OFS_MOD_SET = 4'h3;
    localparam logic [3:0] OFS_MOD_CLR = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PER = 4'h1;
    localparam logic [3:0] OFS_CMPA = 4'h2;
    localparam logic [3:0] OFS_CMPB = 4'h3;
    localparam logic [3:0] OFS_IEN = 4'h4;
    localparam logic [3:0] OFS_RIS = 4'h5;
    localparam logic [3:0] OFS_MIS = 4'h6;
    localparam logic [3:0] OFS_CNT = 4'h7;
    localparam logic [3:0] OFS_ACT = 4'h8;
    localparam logic [3:0] OFS_IEN_SET = 4'h9;
    localparam logic [3:0] OFS_IEN_CLR = 4'ha;
    localparam int NEV = 6;
    localparam int EV_ZERO = 0;
    localparam int EV_LOAD = 1;
    localparam int EV_AU = 2;
    localparam int EV_AD = 3;
    localparam int EV_BU = 4;
    localparam int EV_BD = 5;
    localparam int TRIG_LSB = 8;
    localparam int NTRIG = 4;
    localparam int IEN_W = 12;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_UPDN = 1;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [IEN_W-1:0] RST_IEN = 12'h000;
    localparam logic [NEV-1:0] RST_RIS = 6'h00;
    localparam logic [7:0] RST_MOD_IEN = 8'h00;
    typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} pwg_dir_t;
endpackage : pwg_pkg
`default_nettype wire

// >>> verilog/pwg_gen.sv
`timescale 1ns/1ns
`default_nettype none
module pwg_gen
    import pwg_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_run,
    input wire logic i_updown,
    input wire logic i_per_wr,
    input wire logic [CNT_W-1:0] i_per_wdata,
    input wire logic [CNT_W-1:0] i_cmpa,
    input wire logic [CNT_W-1:0] i_cmpb,
    output logic [CNT_W-1:0] o_count,
    output logic [CNT_W-1:0] o_per_prog,
    output logic [CNT_W-1:0] o_per_act,
    output logic [NEV-1:0] o_evt
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] act_q;
    logic [CNT_W-1:0] pend_q;
    logic pend_vld_q;
    pwg_dir_t dir_q;
    logic [CNT_W-1:0] load_v;
    logic [CNT_W-1:0] new_act;
    logic at_zero;

    assign load_v = i_updown ? (act_q >> 1) : (act_q - 1'b1);
    assign at_zero = (cnt_q == '0);
    assign new_act = pend_vld_q ? pend_q : act_q;

    // (RULE7) Period held pending
    // (RULE8) Latest write wins
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pend_q <= '0;
            pend_vld_q <= 1'b0;
        end
        else if (i_per_wr)
        begin
            pend_q <= i_per_wdata;
            pend_vld_q <= 1'b1;
        end
        else if (i_run && at_zero)
        begin
            pend_vld_q <= 1'b0;
        end
    end

    // (RULE7) Apply at zero
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            act_q <= '0;
        end
        else if (i_run && at_zero)
        begin
            act_q <= new_act;
        end
    end

    // (RULE6) Period tick counter
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cnt_q <= '0;
            dir_q <= DIR_DOWN;
        end
        else if (i_run)
        begin
            if (at_zero)
            begin
                cnt_q <= i_updown ? CNT_W'((new_act >> 1) != '0) : new_act - 1'b1;
                dir_q <= i_updown ? DIR_UP : DIR_DOWN;
            end
            else if (i_updown && dir_q == DIR_UP)
            begin
                if (cnt_q >= load_v)
                begin
                    cnt_q <= cnt_q - 1'b1;
                    dir_q <= DIR_DOWN;
                end
                else
                begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
            else
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // (RULE3) Counter and compare events
    always_comb
    begin
        o_evt = '0;
        if (i_run)
        begin
            o_evt[EV_ZERO] = at_zero;
            o_evt[EV_LOAD] = (cnt_q == load_v);
            o_evt[EV_AU] = (cnt_q == i_cmpa) && (dir_q == DIR_UP);
            o_evt[EV_AD] = (cnt_q == i_cmpa) && (dir_q == DIR_DOWN);
            o_evt[EV_BU] = (cnt_q == i_cmpb) && (dir_q == DIR_UP);
            o_evt[EV_BD] = (cnt_q == i_cmpb) && (dir_q == DIR_DOWN);
        end
    end

    assign o_count = cnt_q;
    assign o_per_prog = pend_q;
    assign o_per_act = act_q;
endmodule : pwg_gen
`default_nettype wire

// >>> verilog/pwg_top.sv
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// (RULE1) Writing one to a generator status bit clears only that bit.
// (RULE2) Raw and masked generator status are readable at separate offsets.
// (RULE3) Six counter and comparator events latch as generator status bits.
// (RULE4) Setting a generator enable bit unmasks that event as interrupt or trigger.
// (RULE5) Clearing an enable bit masks; triggers cover zero, load, B up and down.
// (RULE6) Period equals programmed ticks between successive counter-zero pulses; in up-down mode an odd period above 1 runs one tick short.
// (RULE7) New period applies at next zero; reads return the programmed value.
// (RULE8) Several period writes before update keep only the latest.
// (RULE9) Module enable has one bit per generator and per fault input.
// (RULE10) Software clears the generator source early in its handler.
// (RULE11) Generator request is OR of status AND enable, gated by module enable.
// (RULE12) Writing zero to status has no effect; status resets to zero.
module pwg_top
    import pwg_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_SRST,
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [DW-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DW-1:0] O_RDATA,
    input wire logic [NFLT-1:0] I_FAULT,
    output logic [NGEN-1:0] O_GEN_IRQ,
    output logic [NGEN-1:0] O_TRIG,
    output logic O_IRQ
);
    localparam int PAD = DW - CNT_W;

    logic [2:0] blk;
    logic [3:0] ofs;
    logic [1:0] gidx;
    logic gsel;
    logic mod_wr;
    logic mod_rd;
    logic mod_ien_wr;
    logic mod_set_wr;
    logic mod_clr_wr;
    logic mod_ris_rd;

    logic [7:0] mod_ien_q;
    logic [NFLT-1:0] flt_s1_q;
    logic [NFLT-1:0] flt_s2_q;
    logic [NFLT-1:0] flt_prev_q;
    logic [NFLT-1:0] flt_sts_q;
    logic [NFLT-1:0] flt_clr;
    logic [7:0] mod_ris;
    logic [7:0] mod_mis;

    logic [1:0] ctrl_q [NGEN];
    logic [CNT_W-1:0] cmpa_q [NGEN];
    logic [CNT_W-1:0] cmpb_q [NGEN];
    logic [IEN_W-1:0] ien_q [NGEN];
    logic [NEV-1:0] ris_q [NGEN];
    logic [NEV-1:0] evt [NGEN];
    logic [CNT_W-1:0] cnt [NGEN];
    logic [CNT_W-1:0] per_prog [NGEN];
    logic [CNT_W-1:0] per_act [NGEN];
    logic [NGEN-1:0] gen_irq_raw;
    logic [NGEN-1:0] trig_d;
    logic [NGEN-1:0] gen_irq_d;
    logic irq_d;
    logic [DW-1:0] rdata_d;

    // Address decode
    assign blk = I_ADDR[BLK_LSB +: 3];
    assign ofs = I_ADDR[OFS_LSB +: 4];
    assign gidx = 2'(blk - BLK_GEN0);
    assign gsel = (blk >= BLK_GEN0) && (blk <= BLK_LAST);
    assign mod_wr = I_WR && (blk == BLK_MOD);
    assign mod_rd = I_RD && (blk == BLK_MOD);
    assign mod_ien_wr = mod_wr && (ofs == OFS_MOD_IEN);
    assign mod_set_wr = mod_wr && (ofs == OFS_MOD_SET);
    assign mod_clr_wr = mod_wr && (ofs == OFS_MOD_CLR);
    assign mod_ris_rd = mod_rd && (ofs == OFS_MOD_RIS);

    // (RULE9) Module enable register
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            mod_ien_q <= RST_MOD_IEN;
        end
        else if (mod_ien_wr)
        begin
            mod_ien_q <= I_WDATA[7:0];
        end
        else if (mod_set_wr)
        begin
            mod_ien_q <= mod_ien_q | I_WDATA[7:0];
        end
        else if (mod_clr_wr)
        begin
            mod_ien_q <= mod_ien_q & ~I_WDATA[7:0];
        end
    end

    // Fault pin synchroniser
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            flt_s1_q <= '0;
            flt_s2_q <= '0;
            flt_prev_q <= '0;
        end
        else
        begin
            flt_s1_q <= I_FAULT;
            flt_s2_q <= flt_s1_q;
            flt_prev_q <= flt_s2_q;
        end
    end

    // Fault sticky status, read clears, set wins
    assign flt_clr = mod_ris_rd ? flt_sts_q : '0;
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            flt_sts_q <= '0;
        end
        else
        begin
            flt_sts_q <= (flt_sts_q & ~flt_clr) | (flt_s2_q & ~flt_prev_q);
        end
    end

    assign mod_ris = {flt_sts_q, gen_irq_raw};
    // (RULE9) Module level masking
    assign mod_mis = mod_ris & mod_ien_q;

    genvar g;
    generate
        for (g = 0; g < NGEN; g++)
        begin : g_gen
            localparam logic [2:0] GBLK = 3'(int'(BLK_GEN0) + g);
            logic wr_sel;
            logic per_wr;
            logic ctrl_wr;
            logic cmpa_wr;
            logic cmpb_wr;
            logic ien_wr;
            logic ien_set_wr;
            logic ien_clr_wr;
            logic ris_wr;
            logic [NEV-1:0] clr;
            logic [NTRIG-1:0] trig_src;
            logic [NTRIG-1:0] trig_en;

            // Per register write strobes
            assign wr_sel = I_WR && (blk == GBLK);
            assign per_wr = wr_sel && (ofs == OFS_PER);
            assign ctrl_wr = wr_sel && (ofs == OFS_CTRL);
            assign cmpa_wr = wr_sel && (ofs == OFS_CMPA);
            assign cmpb_wr = wr_sel && (ofs == OFS_CMPB);
            assign ien_wr = wr_sel && (ofs == OFS_IEN);
            assign ien_set_wr = wr_sel && (ofs == OFS_IEN_SET);
            assign ien_clr_wr = wr_sel && (ofs == OFS_IEN_CLR);
            assign ris_wr = wr_sel && (ofs == OFS_RIS);

            always_ff @(posedge I_CORE_CLK)
            begin
                if (I_SRST)
                begin
                    ctrl_q[g] <= RST_CTRL;
                end
                else if (ctrl_wr)
                begin
                    ctrl_q[g] <= I_WDATA[1:0];
                end
            end

            always_ff @(posedge I_CORE_CLK)
            begin
                if (I_SRST)
                begin
                    cmpa_q[g] <= '0;
                    cmpb_q[g] <= '0;
                end
                else if (cmpa_wr)
                begin
                    cmpa_q[g] <= I_WDATA[CNT_W-1:0];
                end
                else if (cmpb_wr)
                begin
                    cmpb_q[g] <= I_WDATA[CNT_W-1:0];
                end
            end

            // (RULE4) Enable set bits
            // (RULE5) Enable clear masks
            always_ff @(posedge I_CORE_CLK)
            begin
                if (I_SRST)
                begin
                    ien_q[g] <= RST_IEN;
                end
                else if (ien_wr)
                begin
                    ien_q[g] <= I_WDATA[IEN_W-1:0];
                end
                else if (ien_set_wr)
                begin
                    ien_q[g] <= ien_q[g] | I_WDATA[IEN_W-1:0];
                end
                else if (ien_clr_wr)
                begin
                    ien_q[g] <= ien_q[g] & ~I_WDATA[IEN_W-1:0];
                end
            end

            // (RULE1) Write one clears
            // (RULE12) Zero writes ignored
            assign clr = ris_wr ? I_WDATA[NEV-1:0] : '0;

            // (RULE3) Latch events, set wins
            // (RULE12) Status resets clear
            always_ff @(posedge I_CORE_CLK)
            begin
                if (I_SRST)
                begin
                    ris_q[g] <= RST_RIS;
                end
                else
                begin
                    ris_q[g] <= (ris_q[g] & ~clr) | evt[g];
                end
            end

            // (RULE6) Period tick counter
            // (RULE7) Deferred period update
            // (RULE8) Latest write kept
            pwg_gen #(
                .CNT_W(CNT_W)
            ) u_gen (
                .i_clk(I_CORE_CLK),
                .i_srst(I_SRST),
                .i_run(ctrl_q[g][CTRL_RUN]),
                .i_updown(ctrl_q[g][CTRL_UPDN]),
                .i_per_wr(per_wr),
                .i_per_wdata(I_WDATA[CNT_W-1:0]),
                .i_cmpa(cmpa_q[g]),
                .i_cmpb(cmpb_q[g]),
                .o_count(cnt[g]),
                .o_per_prog(per_prog[g]),
                .o_per_act(per_act[g]),
                .o_evt(evt[g])
            );

            // (RULE11) Status AND enable
            assign gen_irq_raw[g] = |(ris_q[g] & ien_q[g][NEV-1:0]);
            // (RULE11) Module gate
            assign gen_irq_d[g] = gen_irq_raw[g] & mod_ien_q[g];

            // (RULE5) Trigger source select
            assign trig_src = {evt[g][EV_BD], evt[g][EV_BU], evt[g][EV_LOAD], evt[g][EV_ZERO]};
            assign trig_en = ien_q[g][TRIG_LSB +: NTRIG];
            assign trig_d[g] = |(trig_src & trig_en);
        end
    endgenerate

    assign irq_d = |mod_mis;

    // (RULE11) Generator request outputs
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            O_GEN_IRQ <= '0;
        end
        else
        begin
            O_GEN_IRQ <= gen_irq_d;
        end
    end

    // (RULE5) Trigger pulse outputs
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            O_TRIG <= '0;
        end
        else
        begin
            O_TRIG <= trig_d;
        end
    end

    // (RULE9) Combined interrupt output
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            O_IRQ <= 1'b0;
        end
        else
        begin
            O_IRQ <= irq_d;
        end
    end

    // (RULE2) Raw and masked views
    always_comb
    begin
        rdata_d = '0;
        if (blk == BLK_MOD)
        begin
            case (ofs)
                OFS_MOD_IEN: rdata_d = {24'h000000, mod_ien_q};
                OFS_MOD_RIS: rdata_d = {24'h000000, mod_ris};
                OFS_MOD_MIS: rdata_d = {24'h000000, mod_mis};
                default: rdata_d = '0;
            endcase
        end
        else if (gsel)
        begin
            case (ofs)
                OFS_CTRL: rdata_d = {30'h00000000, ctrl_q[gidx]};
                // (RULE7) Programmed period readback
                OFS_PER: rdata_d = {{PAD{1'b0}}, per_prog[gidx]};
                OFS_CMPA: rdata_d = {{PAD{1'b0}}, cmpa_q[gidx]};
                OFS_CMPB: rdata_d = {{PAD{1'b0}}, cmpb_q[gidx]};
                OFS_IEN: rdata_d = {20'h00000, ien_q[gidx]};
                OFS_RIS: rdata_d = {26'h0000000, ris_q[gidx]};
                OFS_MIS: rdata_d = {26'h0000000, ris_q[gidx] & ien_q[gidx][NEV-1:0]};
                OFS_CNT: rdata_d = {{PAD{1'b0}}, cnt[gidx]};
                OFS_ACT: rdata_d = {{PAD{1'b0}}, per_act[gidx]};
                default: rdata_d = '0;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_SRST)
        begin
            O_RDATA <= '0;
        end
        else if (I_RD)
        begin
            O_RDATA <= rdata_d;
        end
        else
        begin
            O_RDATA <= '0;
        end
    end
endmodule : pwg_top
`default_nettype wire

// >>> sim/pwg_props.sv
`timescale 1ns/1ns
`default_nettype none
module pwg_props
    import pwg_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_SRST,
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [DW-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [DW-1:0] O_RDATA,
    input wire logic [NFLT-1:0] I_FAULT,
    input wire logic [NGEN-1:0] O_GEN_IRQ,
    input wire logic [NGEN-1:0] O_TRIG,
    input wire logic O_IRQ
);
    logic rd_q;
    logic [AW-1:0] a_q;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SRST);
    // Read request history
    always_ff @(posedge I_CORE_CLK)
    begin
        rd_q <= I_RD;
        a_q <= I_ADDR;
    end
    AST_RST_OUT:
        assert property ($fell(I_SRST) |-> O_GEN_IRQ == '0 && O_TRIG == '0 && !O_IRQ)
        else $error("outputs not clear after reset");
    AST_RD_IDLE:
        assert property (!rd_q |-> O_RDATA == '0)
        else $error("read data outside read slot");
    AST_RIS_WIDTH:
        assert property (rd_q && a_q == {BLK_GEN0, OFS_RIS, 2'h0} |-> O_RDATA[DW-1:NEV] == '0)
        else $error("status wider than six events");
    AST_UNMAPPED:
        assert property (rd_q && a_q[8:6] > BLK_LAST |-> O_RDATA == '0)
        else $error("unmapped block read not zero");
    AST_MIEN_WIDTH:
        assert property (rd_q && a_q == {BLK_MOD, OFS_MOD_IEN, 2'h0} |-> O_RDATA[DW-1:8] == '0)
        else $error("module enable wider than eight bits");
    AST_MOD_CLR:
        assert property (I_WR && I_ADDR == {BLK_MOD, OFS_MOD_CLR, 2'h0} && I_WDATA[7:0] == 8'hff
            |=> ##1 (O_GEN_IRQ == '0 && !O_IRQ))
        else $error("interrupt survives module mask");
    AST_IEN_CLR:
        assert property (I_WR && I_ADDR == {BLK_GEN0, OFS_IEN_CLR, 2'h0}
            && I_WDATA[11:0] == 12'hf3f |=> ##1 (!O_GEN_IRQ[0] && !O_TRIG[0])[*4])
        else $error("masked generator still signals");
    AST_GEN_TO_IRQ:
        assert property (O_GEN_IRQ != '0 |-> ##[0:2] O_IRQ)
        else $error("generator request not forwarded");
endmodule : pwg_props
bind pwg_top pwg_props #(.CNT_W(CNT_W)) pwg_props_inst (
    .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_FAULT(I_FAULT),
    .O_GEN_IRQ(O_GEN_IRQ), .O_TRIG(O_TRIG), .O_IRQ(O_IRQ));
`default_nettype wire

// >>> sim/pwg_icm.sv
`timescale 1ns/1ns
`default_nettype none
module pwg_icm
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_irq,
    output logic [7:0] o_entries
);
    logic irq_q;
    // Handler entry on each new request level
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            irq_q <= 1'b0;
            o_entries <= 8'h00;
        end
        else
        begin
            irq_q <= i_irq;
            if (i_irq && !irq_q)
                o_entries <= o_entries + 8'h01;
        end
    end
endmodule : pwg_icm
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import pwg_pkg::*;
();
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [NFLT-1:0] fault = '0;
    logic [DW-1:0] rdata;
    logic [NGEN-1:0] gen_irq;
    logic [NGEN-1:0] trig;
    logic irq;
    logic [7:0] entries;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    localparam logic [AW-1:0] A_MIEN = {BLK_MOD, OFS_MOD_IEN, 2'h0};
    localparam logic [AW-1:0] A_MRIS = {BLK_MOD, OFS_MOD_RIS, 2'h0};
    localparam logic [AW-1:0] A_MMIS = {BLK_MOD, OFS_MOD_MIS, 2'h0};
    localparam logic [AW-1:0] A_MSET = {BLK_MOD, OFS_MOD_SET, 2'h0};
    localparam logic [AW-1:0] A_MCLR = {BLK_MOD, OFS_MOD_CLR, 2'h0};
    always #50 clk = ~clk;
    pwg_top #(.CNT_W(16)) pwg_top_inst (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_en), .I_RD(rd_en), .O_RDATA(rdata), .I_FAULT(fault),
        .O_GEN_IRQ(gen_irq), .O_TRIG(trig), .O_IRQ(irq));
    pwg_icm pwg_icm_inst (.i_clk(clk), .i_srst(srst), .i_irq(irq), .o_entries(entries));
    function automatic logic [AW-1:0] ga(input int g, input logic [3:0] o);
        return {BLK_GEN0 + 3'(g), o, 2'h0};
    endfunction : ga
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [DW-1:0] s, input logic [DW-1:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(nm, rdata, e);
    endtask : rchk
    task automatic meas(output int k);
        k = 0;
        while (trig[0] !== 1'b1 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while (trig[0] !== 1'b1 && k < 200);
    endtask : meas
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int g = 0; g < NGEN; g++)
        begin
            rchk("ris", ga(g, OFS_RIS), 32'h0);
            rchk("per", ga(g, OFS_PER), 32'h0);
        end
        rchk("mien", A_MIEN, 32'h0);
        $display("test reset done");
        wr(ga(0, OFS_IEN), 32'h100);
        wr(ga(0, OFS_PER), 32'h28);
        wr(ga(0, OFS_CTRL), 32'h1);
        meas(n);
        chk("period", n, 32'h28);
        wr(ga(0, OFS_PER), 32'h6);
        wr(ga(0, OFS_PER), 32'h8);
        rchk("act", ga(0, OFS_ACT), 32'h28);
        rchk("per_rd", ga(0, OFS_PER), 32'h8);
        meas(n);
        chk("period_new", n, 32'h8);
        wr(ga(0, OFS_IEN_CLR), 32'hf3f);
        @(posedge clk);
        n = 0;
        repeat (20)
        begin
            @(negedge clk);
            if (trig[0] === 1'b1)
                n++;
        end
        chk("trig_masked", n, 32'h0);
        wr(ga(0, OFS_CTRL), 32'h0);
        $display("test period done");
        wr(ga(1, OFS_PER), 32'h8);
        wr(ga(1, OFS_CMPA), 32'h2);
        wr(ga(1, OFS_CMPB), 32'h3);
        wr(ga(1, OFS_CTRL), 32'h3);
        repeat (20) @(posedge clk);
        wr(ga(1, OFS_CTRL), 32'h0);
        rchk("ris_all", ga(1, OFS_RIS), 32'h3f);
        wr(ga(1, OFS_RIS), 32'h5);
        rchk("ris_w1c", ga(1, OFS_RIS), 32'h3a);
        wr(ga(1, OFS_RIS), 32'h0);
        rchk("ris_w0", ga(1, OFS_RIS), 32'h3a);
        wr(ga(1, OFS_IEN), 32'ha);
        rchk("mis", ga(1, OFS_MIS), 32'ha);
        chk("gen_irq_off", DW'(gen_irq), 32'h0);
        wr(A_MSET, 32'h2);
        repeat (3) @(posedge clk);
        #1;
        chk("gen_irq", DW'(gen_irq), 32'h2);
        chk("entries", DW'(entries), 32'h1);
        wr(ga(1, OFS_RIS), 32'h3f);
        repeat (3) @(posedge clk);
        #1;
        chk("irq_clr", DW'({gen_irq, irq}), 32'h0);
        wr(ga(1, OFS_IEN_CLR), 32'ha);
        rchk("ien", ga(1, OFS_IEN), 32'h0);
        wr(ga(1, OFS_IEN_SET), 32'he00);
        rchk("ien_set", ga(1, OFS_IEN), 32'he00);
        wr(ga(1, OFS_CTRL), 32'h3);
        repeat (2) @(posedge clk);
        n = 0;
        repeat (16)
        begin
            @(negedge clk);
            if (trig[1] === 1'b1)
                n++;
        end
        chk("trig_load_b", n, 32'h6);
        wr(ga(1, OFS_CTRL), 32'h0);
        rchk("mien_set", A_MIEN, 32'h2);
        $display("test status done");
        @(posedge clk);
        fault <= 4'h4;
        wr(A_MSET, 32'h40);
        repeat (4) @(posedge clk);
        #1;
        chk("fault_irq", DW'(irq), 32'h1);
        rchk("mmis", A_MMIS, 32'h40);
        rchk("mris", A_MRIS, 32'h40);
        rchk("mris_rc", A_MRIS, 32'h0);
        chk("fault_irq_clr", DW'(irq), 32'h0);
        wr(A_MIEN, 32'h81);
        rchk("mien_wr", A_MIEN, 32'h81);
        wr(A_MCLR, 32'hff);
        rchk("mien_clr", A_MIEN, 32'h0);
        wr(9'h1c0, 32'hffffffff);
        rchk("unmapped", 9'h1c0, 32'h0);
        $display("test module done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
